// ===== fcs_pkg.sv
`default_nettype none
package fcs_pkg;
   // serial opcodes
   localparam logic [7:0] OPC_LATCH_SET = 8'h06;
   localparam logic [7:0] OPC_SR_WRITE = 8'h01;
   localparam logic [7:0] OPC_SR_WRITE_HI = 8'h31;
   localparam logic [7:0] OPC_BUSY_MON = 8'h25;
   localparam logic [7:0] OPC_SR_READ_LO = 8'h05;
   localparam logic [7:0] OPC_SR_READ_HI = 8'h35;
   localparam logic [7:0] OPC_CFG_WRITE = 8'h11;
   // status register bit positions
   localparam int SR_WIP = 0;
   localparam int SR_WEL = 1;
   localparam int SR_LOCK_LO = 7;
   localparam int SR_LOCK_HI = 8;
   localparam int SR_QE = 9;
   localparam int SR_CMP = 14;
   localparam logic [15:0] SR_RESET = 16'h0000;
   localparam logic [15:0] SR_KEEP_MASK = 16'h8403;
   localparam logic [15:0] SR_BYTE1_CLEAR = 16'h4300;
   // configuration register
   localparam logic [7:0] CFG_RESET = 8'h40;
   localparam logic [7:0] CFG_WRITE_MASK = 8'hF4;
   localparam logic [1:0] DRV_DEFAULT = 2'h2;
   localparam logic [9:0] PAGE_WRAP_SMALL = 10'h0FF;
   localparam logic [9:0] PAGE_WRAP_WIDE = 10'h3FF;
   // frame lengths in serial clocks, opcode included
   localparam logic [5:0] BITS_OPC = 6'h08;
   localparam logic [5:0] BITS_ONE_BYTE = 6'h10;
   localparam logic [5:0] BITS_TWO_BYTES = 6'h18;
   localparam logic [5:0] BITS_MAX = 6'h3F;
   // timing
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned STATUS_WRITE_TIME_NS_DEF = 8000000;

   typedef enum logic [2:0] {ST_OPC, ST_DATA, ST_READ, ST_MON, ST_SKIP} fcs_state_t;

   typedef struct packed {
      logic hold_rst;
      logic [1:0] drv;
      logic wide_page_enable;
      logic rsv3;
      logic protect_scheme_select;
      logic [1:0] rsv10;
   } fcs_cfg_t;
endpackage : fcs_pkg
`default_nettype wire

// ===== fcs_top.sv
`default_nettype none
module fcs_top
   import fcs_pkg::*;
#(
   parameter int unsigned STATUS_WRITE_TIME_NS = STATUS_WRITE_TIME_NS_DEF,
   parameter bit ORDER_ALT = 1'b0,
   parameter int unsigned NUM_LOCKS = 16
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // serial link pins
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic si_i,
   input wire logic wp_n_i,
   output logic so_o,
   output logic so_oe_o,
   // configuration effects
   output logic hold_en_o,
   output logic reset_en_o,
   output logic [1:0] drive_sel_o,
   output logic [9:0] page_wrap_mask_o,
   output logic erase_quad_page_o,
   output logic prot_use_locks_o,
   output logic [NUM_LOCKS-1:0] block_lock_o,
   // register views
   output logic [15:0] status_o,
   output logic [7:0] config_o
);
   localparam int unsigned TW_CYCLES =
      (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [31:0] TW_LAST = 32'(TW_CYCLES - 1);

   logic [2:0] cs_sr;
   logic [2:0] sclk_sr;
   logic [1:0] si_sr;
   logic [1:0] wp_sr;
   fcs_state_t state;
   logic [7:0] opc;
   logic [15:0] shreg;
   logic [5:0] bit_cnt;
   logic [2:0] out_idx;
   logic [15:0] status;
   fcs_cfg_t cfg;
   logic [31:0] tw_cnt;

   // pin synchronisers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cs_sr <= 3'h7;
         sclk_sr <= 3'h0;
         si_sr <= 2'h0;
         wp_sr <= 2'h0;
      end else begin
         cs_sr <= {cs_sr[1:0], cs_n_i};
         sclk_sr <= {sclk_sr[1:0], sclk_i};
         si_sr <= {si_sr[0], si_i};
         wp_sr <= {wp_sr[0], wp_n_i};
      end
   end

   wire cs_high = cs_sr[1];
   wire cs_fall = !cs_sr[1] && cs_sr[2];
   wire cs_rise = cs_sr[1] && !cs_sr[2];
   wire sclk_rise = !cs_high && sclk_sr[1] && !sclk_sr[2];
   wire sclk_fall = !cs_high && !sclk_sr[1] && sclk_sr[2];
   wire si = si_sr[1];
   wire wp_n = wp_sr[1];

   wire write_in_progress = status[SR_WIP];
   wire write_enable_latch = status[SR_WEL];
   wire [7:0] opc_next = {opc[6:0], si};
   wire opc_done = (state == ST_OPC) && sclk_rise && (bit_cnt == BITS_OPC - 6'h01);

   // opcode decode
   wire is_read = (opc_next == OPC_SR_READ_LO) || (opc_next == OPC_SR_READ_HI);
   wire is_mon = (opc_next == OPC_BUSY_MON);
   wire is_wr = (opc_next == OPC_SR_WRITE) || (opc_next == OPC_CFG_WRITE) ||
                (opc_next == OPC_SR_WRITE_HI && !ORDER_ALT);

   // protection
   wire [1:0] sr_lock = {status[SR_LOCK_HI], status[SR_LOCK_LO]};
   wire hw_locked = sr_lock[1] || (sr_lock == 2'h1 && !wp_n);
   wire wr_allowed = write_enable_latch && !write_in_progress;

   // end of frame decisions
   wire end_wr = cs_rise && (state == ST_DATA);
   wire sr_one = (opc == OPC_SR_WRITE) && (bit_cnt == BITS_ONE_BYTE);
   wire sr_two = (opc == OPC_SR_WRITE) && (bit_cnt == BITS_TWO_BYTES);
   wire sr_hi = (opc == OPC_SR_WRITE_HI) && (bit_cnt == BITS_ONE_BYTE);
   wire sr_commit = end_wr && (sr_one || sr_two || sr_hi) && wr_allowed && !hw_locked;
   wire cfg_commit = end_wr && (opc == OPC_CFG_WRITE) && (bit_cnt == BITS_ONE_BYTE) &&
                     wr_allowed;
   wire latch_set_cmd_commit = cs_rise && (state == ST_SKIP) && (opc == OPC_LATCH_SET) &&
                      (bit_cnt == BITS_OPC) && !write_in_progress;
   wire tw_done = write_in_progress && (tw_cnt == TW_LAST);

   wire [15:0] sr_cand = sr_two ? {shreg[7:0], shreg[15:8]} :
                         sr_hi ? {shreg[7:0], status[7:0]} :
                         {status[15:8], shreg[7:0]};
   wire [15:0] sr_merged = (sr_cand & ~SR_KEEP_MASK) | (status & SR_KEEP_MASK);
   wire [15:0] next_status = sr_one ? (sr_merged & ~SR_BYTE1_CLEAR) : sr_merged;

   wire [7:0] rd_byte = (opc == OPC_SR_READ_HI) ? status[15:8] : status[7:0];

   // command sequencer
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_SKIP;
         opc <= 8'h00;
         shreg <= 16'h0000;
         bit_cnt <= 6'h00;
      end else if (cs_fall) begin
         state <= ST_OPC;
         opc <= 8'h00;
         bit_cnt <= 6'h00;
      end else if (sclk_rise) begin
         if (bit_cnt != BITS_MAX) begin
            bit_cnt <= bit_cnt + 6'h01;
         end
         shreg <= {shreg[14:0], si};
         if (state == ST_OPC) begin
            opc <= opc_next;
         end
         if (opc_done) begin
            if (is_read) begin
               state <= ST_READ;
            end else if (is_mon) begin
               state <= ST_MON;
            end else if (is_wr) begin
               state <= ST_DATA;
            end else begin
               state <= ST_SKIP;
            end
         end
      end
   end

   // serial output: status read or busy monitor
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         so_o <= 1'b0;
         so_oe_o <= 1'b0;
         out_idx <= 3'h0;
      end else if (cs_high) begin
         so_oe_o <= 1'b0;
         out_idx <= 3'h0;
      end else if (state == ST_MON) begin
         so_oe_o <= 1'b1;
         so_o <= write_in_progress;
      end else if (state == ST_READ && sclk_fall) begin
         so_oe_o <= 1'b1;
         so_o <= rd_byte[3'h7 - out_idx];
         out_idx <= out_idx + 3'h1;
      end
   end

   // status register and self-timed cycle
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status <= SR_RESET;
         tw_cnt <= 32'h0;
      end else if (sr_commit) begin
         status <= next_status | 16'h0003;
         tw_cnt <= 32'h0;
      end else if (cfg_commit) begin
         status[SR_WIP] <= 1'b1;
         tw_cnt <= 32'h0;
      end else if (tw_done) begin
         status[SR_WIP] <= 1'b0;
         status[SR_WEL] <= 1'b0;
      end else if (write_in_progress) begin
         tw_cnt <= tw_cnt + 32'h1;
      end else if (latch_set_cmd_commit) begin
         status[SR_WEL] <= 1'b1;
      end
   end

   // configuration register, reserved bits held at zero
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg <= fcs_cfg_t'(CFG_RESET);
      end else if (cfg_commit) begin
         cfg <= fcs_cfg_t'(shreg[7:0] & CFG_WRITE_MASK);
      end
   end

   // registered configuration effects
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hold_en_o <= 1'b0;
         reset_en_o <= 1'b0;
         drive_sel_o <= DRV_DEFAULT;
         page_wrap_mask_o <= PAGE_WRAP_SMALL;
         erase_quad_page_o <= 1'b0;
         prot_use_locks_o <= 1'b0;
         block_lock_o <= '1;
      end else begin
         hold_en_o <= !status[SR_QE] && !cfg.hold_rst;
         reset_en_o <= !status[SR_QE] && cfg.hold_rst;
         drive_sel_o <= ORDER_ALT ? DRV_DEFAULT : cfg.drv;
         page_wrap_mask_o <= cfg.wide_page_enable ? PAGE_WRAP_WIDE : PAGE_WRAP_SMALL;
         erase_quad_page_o <= cfg.wide_page_enable;
         prot_use_locks_o <= cfg.protect_scheme_select;
      end
   end

   assign status_o = status;
   assign config_o = cfg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   property p_mon_live;
      (state == ST_MON && !cs_high) |=> (so_oe_o && so_o == $past(write_in_progress));
   endproperty
   a_mon_live: assert property (p_mon_live) else $error("monitor output not live busy");

   property p_mon_no_rise;
      (state == ST_MON && so_oe_o && !so_o && !cs_high) |=> !so_o;
   endproperty
   a_mon_no_rise: assert property (p_mon_no_rise) else $error("monitored busy rose");

   property p_cs_end;
      cs_high ##1 cs_high |-> !so_oe_o;
   endproperty
   a_cs_end: assert property (p_cs_end) else $error("output enabled with cs high");

   property p_need_wel;
      sr_commit |-> $past(write_enable_latch) && write_enable_latch && !write_in_progress;
   endproperty
   a_need_wel: assert property (p_need_wel) else $error("status write without latch");

   property p_keep_bits;
      sr_commit |=> status[15] == $past(status[15]) && status[10] == $past(status[10]);
   endproperty
   a_keep_bits: assert property (p_keep_bits) else $error("protected status bit changed");

   property p_frame;
      sr_commit |-> (bit_cnt == BITS_ONE_BYTE || bit_cnt == BITS_TWO_BYTES);
   endproperty
   a_frame: assert property (p_frame) else $error("status write off frame");

   property p_one_byte;
      (sr_commit && sr_one) |=> !status[SR_CMP] && !status[SR_QE] && !status[SR_LOCK_HI];
   endproperty
   a_one_byte: assert property (p_one_byte) else $error("one byte write kept bits");

   property p_tw_end;
      $fell(write_in_progress) |-> !write_enable_latch && $past(tw_cnt) == TW_LAST;
   endproperty
   a_tw_end: assert property (p_tw_end) else $error("timed cycle end wrong");

   property p_hw_lock;
      (end_wr && hw_locked) |=> !$rose(write_in_progress);
   endproperty
   a_hw_lock: assert property (p_hw_lock) else $error("write in protected mode");

   property p_drive_alt;
      ORDER_ALT |-> drive_sel_o == DRV_DEFAULT;
   endproperty
   a_drive_alt: assert property (p_drive_alt) else $error("drive changed on variant");

   property p_quad_pin;
      status[SR_QE] ##1 status[SR_QE] |-> !hold_en_o && !reset_en_o;
   endproperty
   a_quad_pin: assert property (p_quad_pin) else $error("hold or reset with quad");

   c_mon: cover property (state == ST_MON && so_oe_o && $fell(so_o));
   c_two_byte: cover property (sr_commit && sr_two);
   c_read_busy: cover property (state == ST_READ && so_oe_o && write_in_progress);
endmodule : fcs_top
`default_nettype wire

// ===== fcs_host.sv
`default_nettype none
module fcs_host (
   // clock, and serial pins to and from the device
   input wire logic clk_i,
   input wire logic so_i,
   output logic cs_n_o,
   output logic sclk_o,
   output logic si_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      si_o = 1'b0;
   end
   task automatic half();
      repeat (4) @(posedge clk_i);
      #1;
   endtask
   // mode 0 host: no dummy bit after the monitor opcode
   task automatic start(input logic [23:0] bits, input int n);
      @(posedge clk_i);
      #1;
      cs_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         si_o = bits[23-i];
         half();
         sclk_o = 1'b1;
         half();
         sclk_o = 1'b0;
      end
      // data line left by the host shows no stale value
      si_o = ~si_o;
   endtask
   // shifts one byte out of the device, sampled just before each rising clock
   task automatic read_byte(output logic [7:0] b);
      b = 8'h00;
      for (int i = 0; i < 8; i++) begin
         half();
         b = {b[6:0], so_i};
         sclk_o = 1'b1;
         half();
         sclk_o = 1'b0;
      end
   endtask
   // frame ends where the caller's bit count says
   task automatic stop();
      half();
      cs_n_o = 1'b1;
      half();
   endtask
endmodule // fcs_host
`default_nettype wire

// ===== fcs_tb_top.sv
`default_nettype none
module fcs_tb_top import fcs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_n_i, wp_n_i, cs_n, sclk, si, so, so_oe, hold, rst_en, erase, prot;
   logic [1:0] drv;
   logic [9:0] wrap;
   logic [15:0] locks, status;
   logic [7:0] cfg;
   int num_errors = 0;
   int checks = 0;
   int run = 0;
   int last_run = 0;
   fcs_top #(.STATUS_WRITE_TIME_NS(4000)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si), .wp_n_i(wp_n_i), .so_o(so),
      .so_oe_o(so_oe), .hold_en_o(hold), .reset_en_o(rst_en), .drive_sel_o(drv),
      .page_wrap_mask_o(wrap), .erase_quad_page_o(erase), .prot_use_locks_o(prot),
      .block_lock_o(locks), .status_o(status), .config_o(cfg));
   fcs_host host (.clk_i(clk_i), .so_i(so), .cs_n_o(cs_n), .sclk_o(sclk), .si_o(si));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   // length of the last busy stretch in clocks
   always @(posedge clk_i) begin
      if (status[0] === 1'b1) run <= run + 1;
      else if (run != 0) begin
         last_run <= run;
         run <= 0;
      end
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic idle();
      int k;
      for (k = 0; k < 300 && status[0] !== 1'b0; k++) @(posedge clk_i);
      if (k == 300) begin
         num_errors++;
         complete_run();
      end
      repeat (6) @(posedge clk_i);
      #1;
   endtask
   task automatic send(input logic [23:0] b, input int n);
      host.start(b, n);
      host.stop();
   endtask
   task automatic wr(input logic [23:0] b, input int n);
      send({OPC_LATCH_SET, 16'h0000}, 8);
      send(b, n);
      idle();
   endtask
   task automatic t_reset();
      chk("status", status, 16'h0000);
      chk("config", cfg, 8'h40);
      chk("pins", {hold, rst_en, drv, erase, prot, so_oe}, 7'b1010000);
      chk("wrap", wrap, 10'h0FF);
      chk("locks", locks, 16'hFFFF);
      $display("test reset done");
   endtask
   task automatic t_nolatch();
      send({OPC_SR_WRITE, 16'hFC00}, 16);
      idle();
      chk("no_latch", status, 16'h0000);
      $display("test no latch done");
   endtask
   task automatic t_write_mon();
      int k;
      send({OPC_LATCH_SET, 16'h0000}, 8);
      send({OPC_SR_WRITE, 16'h7F7E}, 24);
      host.start({OPC_BUSY_MON, 16'h0000}, 8);
      repeat (5) @(posedge clk_i);
      #1;
      chk("mon_on", {so_oe, so}, 2'b11);
      for (k = 0; k < 200 && so === 1'b1; k++) @(posedge clk_i);
      #1;
      chk("mon_fall", so, 1'b0);
      repeat (8) @(posedge clk_i);
      #1;
      chk("mon_stay", {so_oe, so}, 2'b10);
      host.stop();
      chk("mon_off", so_oe, 1'b0);
      idle();
      chk("sr16", status, 16'h7A7C);
      chk("busy_len", last_run, 100);
      chk("quad", {hold, rst_en}, 2'b00);
      $display("test write and monitor done");
   endtask
   task automatic t_short();
      wr({OPC_SR_WRITE, 16'h0000}, 16);
      chk("sr8", status, 16'h3800);
      chk("hold", hold, 1'b1);
      wr({OPC_SR_WRITE, 16'hFFFF}, 20);
      chk("frame", status, 16'h3802);
      send({OPC_SR_WRITE_HI, 16'h4000}, 16);
      idle();
      chk("hi_byte", status, 16'h4000);
      $display("test framing done");
   endtask
   task automatic t_hwlock();
      wr({OPC_SR_WRITE, 16'h8000}, 16);
      chk("lock_lo", status, 16'h0080);
      wp_n_i = 1'b0;
      wr({OPC_SR_WRITE, 16'h0400}, 16);
      chk("hw_lock", status, 16'h0082);
      wp_n_i = 1'b1;
      wr({OPC_SR_WRITE, 16'h0000}, 16);
      chk("unlock", status, 16'h0000);
      $display("test hardware lock done");
   endtask
   task automatic t_cfg();
      logic [7:0] vals [3] = '{8'hFF, 8'h20, 8'h00};
      foreach (vals[i]) begin
         wr({OPC_CFG_WRITE, vals[i], 8'h00}, 16);
         chk("config", cfg, vals[i] & 8'hF4);
         chk("effects", {rst_en, hold, drv, wrap, erase, prot}, {vals[i][7], ~vals[i][7],
            vals[i][6:5], vals[i][4] ? 10'h3FF : 10'h0FF, vals[i][4], vals[i][2]});
      end
      $display("test config done");
   endtask
   task automatic t_read();
      logic [7:0] b;
      send({OPC_LATCH_SET, 16'h0000}, 8);
      send({OPC_SR_WRITE_HI, 16'h4000}, 16);
      host.start({OPC_SR_READ_HI, 16'h0000}, 8);
      chk("read_wip", status[0], 1'b1);
      host.read_byte(b);
      host.stop();
      chk("read_hi", b, 8'h40);
      idle();
      host.start({OPC_SR_READ_LO, 16'h0000}, 8);
      host.read_byte(b);
      host.stop();
      chk("read_lo", b, 8'h00);
      $display("test status read done");
   endtask
   initial begin
      rst_n_i = 1'b0;
      wp_n_i = 1'b1;
      repeat (6) @(posedge clk_i);
      #1;
      rst_n_i = 1'b1;
      repeat (4) @(posedge clk_i);
      #1;
      t_reset();
      t_nolatch();
      t_write_mon();
      t_short();
      t_hwlock();
      t_cfg();
      t_read();
      complete_run();
   end
endmodule // fcs_tb_top
`default_nettype wire
